// *** hw/spims_pkg.sv ***
// Shared types and constants of the serial master/slave port.
// Assumes a single 250 MHz clock and no register bus.
package spims_pkg;

	// ---------------------------------------------------------------
	// Counts and reset values
	// ---------------------------------------------------------------
	localparam int SPIMS_BITS = 8;
	localparam logic [4:0] SPIMS_LAST_EDGE = 5'h0F;
	localparam logic [3:0] SPIMS_LAST_BIT = 4'h7;
	// Half periods of the master clock, indexed by {double, hi, lo}.
	localparam logic [6:0] SPIMS_HALF [8] = '{7'h02, 7'h08, 7'h20,
		7'h40, 7'h01, 7'h04, 7'h10, 7'h20};

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic transfer_irq_enable;
		logic port_enable;
		logic bit_order_select;
		logic controller_select;
		logic cpol;
		logic cpha;
		logic rate_select_hi;
		logic rate_select_lo;
		logic double_speed;
	} spims_ctrl_s;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} spims_pins_s;

	localparam spims_ctrl_s SPIMS_CTRL_RESET = '0;
	localparam int SPIMS_SCK = 3;
	localparam int SPIMS_MOSI = 2;
	localparam int SPIMS_MISO = 1;
	localparam int SPIMS_SS = 0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_MASTER = 3'h2,
		ST_SLAVE = 3'h4
	} spims_state_e;

endpackage : spims_pkg

// *** hw/spims_port.sv ***
// Byte-wide full-duplex serial port, master or slave, with its controls
// as plain ports. Assumes the pad logic joins the pin enables to wires.
// What this block does
// - As master the block never drives select; software does.
// - Master: a data write starts the clock and shifts eight bits.
// - Master: after one byte the clock stops and the done flag sets.
// - Done flag with interrupt enable raises the interrupt, any mode.
// - Data goes out on MOSI as master, MISO as slave, simultaneously.
// - The last received byte is held in the receive buffer.
// - Slave with select high idles, MISO undriven, clock ignored.
// - Slave writes while select high are kept, shifted after select low.
// - Slave sets the done flag after a full byte.
// - Enabled port forces the mode's input pins to input; its output pins drive only where pin_dir asks.
// - Master clock divides by 4,16,64,128 or 2,8,32,64 at double speed.
// - Polarity sets idle level; phase picks leading or trailing sample.
// - Bit order select one sends LSB first, zero MSB first.
// - Select input low as master, with pin_dir.ss_n low, drops to slave and sets the flag.
`timescale 1ns/1ns
module spims_port
	import spims_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Control register load and user pin directions
	input wire logic ctrl_write,
	input wire spims_ctrl_s ctrl_in,
	input wire spims_pins_s pin_dir,
	// Data register and flag
	input wire logic data_write,
	input wire logic [7:0] data_in,
	input wire logic flag_clear,
	output logic [7:0] rx_data,
	output logic transfer_done_flag,
	output logic irq,
	output logic controller_select,
	// Pins
	input wire spims_pins_s pin_in,
	output logic sck_out,
	output logic sck_oe,
	output logic mosi_out,
	output logic mosi_oe,
	output logic miso_out,
	output logic miso_oe
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] s1, s2, s3, filt;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					s1[gi] <= 1'b1;
					s2[gi] <= 1'b1;
					s3[gi] <= 1'b1;
					filt[gi] <= 1'b1;
				end else begin
					s1[gi] <= pin_in[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					if (s2[gi] == s3[gi]) begin
						filt[gi] <= s3[gi];
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Shift engine
	// ---------------------------------------------------------------
	function automatic logic head(input logic [7:0] v, input logic lsb);
		head = lsb ? v[0] : v[7];
	endfunction : head

	function automatic logic [7:0] push(input logic [7:0] v,
			input logic b, input logic lsb);
		push = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction : push

	spims_state_e state, next_state;
	spims_ctrl_s ctrl, next_ctrl;
	logic [7:0] sh, next_sh, next_rx;
	logic [6:0] div, next_div, half;
	logic [4:0] edges, next_edges;
	logic [3:0] bits, next_bits;
	logic sck_prev, next_sck, next_out, out_q, next_flag, abort, done_ev;
	logic next_mosi_oe, next_miso_oe, next_sck_oe, slave_act;
	logic sck_edge, lead;

	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_sh = sh;
		next_rx = rx_data;
		next_div = div;
		next_edges = edges;
		next_bits = bits;
		next_sck = sck_out;
		next_out = out_q;
		next_flag = transfer_done_flag;
		done_ev = 1'b0;
		half = SPIMS_HALF[{ctrl.double_speed, ctrl.rate_select_hi,
			ctrl.rate_select_lo}];
		sck_edge = filt[SPIMS_SCK] != sck_prev;
		lead = filt[SPIMS_SCK] != ctrl.cpol;
		abort = ctrl.port_enable && ctrl.controller_select
			&& !pin_dir.ss_n && !filt[SPIMS_SS];
		if (flag_clear) begin
			next_flag = 1'b0;
		end
		if (ctrl_write) begin
			next_ctrl = ctrl_in;
		end
		unique case (state)
			ST_IDLE: begin
				next_sck = ctrl.cpol;
				if (ctrl.port_enable && ctrl.controller_select) begin
					// Select is left entirely to software here.
					if (data_write) begin
						next_sh = data_in;
						next_out = head(data_in, ctrl.bit_order_select);
						next_div = '0;
						next_edges = '0;
						next_state = ST_MASTER;
					end
				end else if (ctrl.port_enable) begin
					if (data_write) begin
						next_sh = data_in;
					end
					if (!filt[SPIMS_SS]) begin
						next_bits = '0;
						next_out = head(next_sh, ctrl.bit_order_select);
						next_state = ST_SLAVE;
					end
				end
			end
			ST_MASTER: begin
				next_div = div + 7'h01;
				if (div == half - 7'h01) begin
					next_div = '0;
					next_sck = !sck_out;
					next_edges = edges + 5'h01;
					// Leading edges are the even ones; CPHA picks sampling.
					if (edges[0] == ctrl.cpha) begin
						next_sh = push(sh, filt[SPIMS_MISO],
							ctrl.bit_order_select);
					end else begin
						next_out = head(sh, ctrl.bit_order_select);
					end
					if (edges == SPIMS_LAST_EDGE) begin
						next_state = ST_IDLE;
						next_rx = next_sh;
						next_flag = 1'b1;
						done_ev = 1'b1;
					end
				end
				// Later writes are ignored until the byte ends.
			end
			ST_SLAVE: begin
				if (filt[SPIMS_SS] || !ctrl.port_enable
						|| ctrl.controller_select) begin
					next_state = ST_IDLE;
					next_bits = '0;
				end else if (sck_edge && (lead != ctrl.cpha)) begin
					next_sh = push(sh, filt[SPIMS_MOSI],
						ctrl.bit_order_select);
					next_bits = bits + 4'h1;
					if (bits == SPIMS_LAST_BIT) begin
						next_bits = '0;
						// An unread byte is overwritten here.
						next_rx = next_sh;
						next_flag = 1'b1;
						done_ev = 1'b1;
					end
				end else if (sck_edge) begin
					next_out = head(sh, ctrl.bit_order_select);
				end else if (data_write && bits == 4'h0) begin
					next_sh = data_in;
					next_out = head(data_in, ctrl.bit_order_select);
				end
			end
		endcase
		if (abort) begin
			next_ctrl.controller_select = 1'b0;
			next_flag = 1'b1;
			next_state = ST_IDLE;
			next_sck = ctrl.cpol;
		end
		// Pin directions follow the mode the block will be in.
		slave_act = next_ctrl.port_enable && !next_ctrl.controller_select;
		next_mosi_oe = next_ctrl.port_enable
			&& next_ctrl.controller_select && pin_dir.mosi;
		next_sck_oe = next_ctrl.port_enable
			&& next_ctrl.controller_select && pin_dir.sck;
		next_miso_oe = slave_act && pin_dir.miso
			&& next_state == ST_SLAVE;
	end

	// The external clock is only seen through the synchroniser, so it
	// must stay at or below a quarter of this clock.
	// Master reads MISO through the same filter, which costs about four
	// cycles; divisors 2, 4 and 8 sample it before it settles.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			ctrl <= SPIMS_CTRL_RESET;
			sh <= '0;
			rx_data <= '0;
			div <= '0;
			edges <= '0;
			bits <= '0;
			sck_prev <= 1'b1;
			sck_out <= 1'b0;
			out_q <= 1'b0;
			mosi_out <= 1'b0;
			miso_out <= 1'b0;
			transfer_done_flag <= 1'b0;
			irq <= 1'b0;
			controller_select <= 1'b0;
			sck_oe <= 1'b0;
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			sh <= next_sh;
			rx_data <= next_rx;
			div <= next_div;
			edges <= next_edges;
			bits <= next_bits;
			sck_prev <= filt[SPIMS_SCK];
			sck_out <= next_sck;
			out_q <= next_out;
			mosi_out <= next_out;
			miso_out <= next_out;
			transfer_done_flag <= next_flag;
			irq <= next_flag && next_ctrl.transfer_irq_enable;
			controller_select <= next_ctrl.controller_select;
			sck_oe <= next_sck_oe;
			mosi_oe <= next_mosi_oe;
			miso_oe <= next_miso_oe;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_start;
		@(posedge clock) disable iff (reset)
		state == ST_IDLE && ctrl.port_enable && ctrl.controller_select
			&& data_write && !abort && !ctrl_write
			|=> state == ST_MASTER && edges == 5'h00;
	endproperty
	a_start: assert property (p_start) else $error("write did not start");

	property p_done;
		@(posedge clock) disable iff (reset)
		state == ST_MASTER && edges == SPIMS_LAST_EDGE
			&& div == half - 7'h01 && !abort
			|=> transfer_done_flag && state == ST_IDLE;
	endproperty
	a_done: assert property (p_done) else $error("master byte not ended");

	property p_irq;
		@(posedge clock) disable iff (reset)
		$rose(transfer_done_flag) && ctrl.transfer_irq_enable |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_hiz;
		@(posedge clock) disable iff (reset)
		!ctrl.controller_select && filt[SPIMS_SS] ##1 !ctrl_write
			|-> !miso_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("MISO driven while idle");

	property p_rx;
		@(posedge clock) disable iff (reset)
		done_ev |=> rx_data == $past(next_sh) && transfer_done_flag;
	endproperty
	a_rx: assert property (p_rx) else $error("receive buffer wrong");

	property p_preload;
		@(posedge clock) disable iff (reset)
		state == ST_IDLE && ctrl.port_enable && !ctrl.controller_select
			&& data_write |=> sh == $past(data_in);
	endproperty
	a_preload: assert property (p_preload) else $error("preload lost");

	property p_slave_pins;
		@(posedge clock) disable iff (reset)
		(ctrl.port_enable && !ctrl.controller_select)[*2]
			|-> !mosi_oe && !sck_oe;
	endproperty
	a_slave_pins: assert property (p_slave_pins)
		else $error("slave drives an input pin");

	property p_idle_sck;
		@(posedge clock) disable iff (reset)
		(state == ST_IDLE && !ctrl_write)[*2] |-> sck_out == ctrl.cpol;
	endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("bad idle SCK");

	property p_demote;
		@(posedge clock) disable iff (reset)
		abort |=> !controller_select && transfer_done_flag
			&& state == ST_IDLE;
	endproperty
	a_demote: assert property (p_demote) else $error("no demotion");

	property p_rate;
		@(posedge clock) disable iff (reset)
		state == ST_MASTER && $changed(sck_out) && !abort
			&& $past(state) == ST_MASTER
			|-> $past(div) == half - 7'h01;
	endproperty
	a_rate: assert property (p_rate) else $error("SCK toggled off rate");

endmodule : spims_port

// *** dv/spims_partner.sv ***
// Behavioural serial peripheral sitting on the far side of the port.
// Assumes select, clock and data come straight from the bench pins.
`timescale 1ns/1ns
module spims_partner (
	// Wires from the controller
	input wire logic ss_n,
	input wire logic sck,
	input wire logic mosi,
	// Mode of the link
	input wire logic cpol,
	input wire logic cpha,
	// Byte to send and byte seen
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	logic [7:0] sh;
	int k;

	initial begin
		miso = 1'b0;
		rx = '0;
		sh = '0;
		k = 0;
	end

	// Phase zero needs the first bit before the first clock edge.
	always @(negedge ss_n) begin
		sh = tx;
		k = 0;
		if (!cpha) begin
			miso = sh[7];
			k = 1;
		end
	end

	// A released line must not keep showing the last bit.
	always @(posedge ss_n) begin
		miso = ~miso;
	end

	always @(sck) begin
		if (!ss_n) begin
			if ((sck !== cpol) ^ cpha) begin
				rx = {rx[6:0], mosi};
			end else if (k < 8) begin
				miso = sh[7 - k];
				k++;
			end
		end
	end
endmodule : spims_partner

// *** dv/testbench.sv ***
// Self-checking bench for the serial port, master and slave modes.
// Assumes the partner model stands on the pins in master mode.
`timescale 1ns/1ns
module testbench;
	import spims_pkg::*;
	logic clock = 0, reset = 1, ctrl_write = 0, data_write = 0;
	logic flag_clear = 0, bm = 0, b_sck = 0, b_mosi = 0;
	logic ss_in = 1, psel_n = 1, p_miso;
	spims_ctrl_s ctrl = '0;
	spims_pins_s pin_dir = 4'hC, pin_in;
	logic [7:0] data_in = '0, rx_data, p_tx = '0, p_rx, g, m;
	logic transfer_done_flag, irq, controller_select, sck_out, sck_oe;
	logic mosi_out, mosi_oe, miso_out, miso_oe;
	int errors = 0, comparisons = 0, seed = 32'hac57a668, n;
	int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	// Half periods under five cycles are left out: MISO passes the pin
	// filter and would be sampled before it settles.
	int rates[3] = '{1, 6, 7};

	always #2 clock = ~clock;

	assign pin_in = bm ? {b_sck, b_mosi, 1'b1, ss_in}
		: {sck_out, mosi_out, p_miso, ss_in};

	spims_port u_spims_port (.clock(clock), .reset(reset),
		.ctrl_write(ctrl_write), .ctrl_in(ctrl), .pin_dir(pin_dir),
		.data_write(data_write), .data_in(data_in),
		.flag_clear(flag_clear), .rx_data(rx_data),
		.transfer_done_flag(transfer_done_flag), .irq(irq),
		.controller_select(controller_select), .pin_in(pin_in),
		.sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe));

	spims_partner u_spims_partner (.ss_n(psel_n), .sck(sck_out),
		.mosi(mosi_out), .cpol(ctrl.cpol), .cpha(ctrl.cpha), .tx(p_tx),
		.miso(p_miso), .rx(p_rx));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task chk(input string what, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", what, e, s);
		end
	endtask : chk

	task conclude;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	task tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick

	task ctl(input spims_ctrl_s c);
		ctrl = c;
		ctrl_write = 1;
		tick(1);
		ctrl_write = 0;
		tick(1);
	endtask : ctl

	task wflag(input int lim);
		n = 0;
		while (transfer_done_flag !== 1'b1) begin
			tick(1);
			n++;
			if (n > lim) begin
				errors++;
				conclude();
			end
		end
	endtask : wflag

	task clr;
		flag_clear = 1;
		tick(1);
		flag_clear = 0;
		tick(1);
		chk("flag_cleared", 0, transfer_done_flag);
	endtask : clr

	function automatic logic [7:0] rev(input logic [7:0] x, input logic l);
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
			r[i] = x[7 - i];
		return l ? r : x;
	endfunction : rev

	// ---------------------------------------------------------------
	// Master byte against the partner
	// ---------------------------------------------------------------
	task mx(input logic [2:0] r, input logic pol, pha, lsb);
		logic [7:0] d, t;
		logic ie;
		d = $random(seed);
		t = $random(seed);
		ie = $random(seed);
		ctl({ie, 1'b1, lsb, 1'b1, pol, pha, r[1:0], r[2]});
		p_tx = t;
		psel_n = 0;
		tick(2);
		chk("miso_oe", 0, miso_oe);
		chk("sck_oe", 1, sck_oe);
		chk("mosi_oe", 1, mosi_oe);
		chk("sck_idle", pol, sck_out);
		data_in = d;
		data_write = 1;
		tick(1);
		data_write = 0;
		wflag(2100);
		chk("cycles", 16 * (dv[r] / 2), n);
		chk("rx_data", rev(t, lsb), rx_data);
		chk("peer_rx", rev(d, lsb), p_rx);
		chk("irq", ie, irq);
		chk("sck_stop", pol, sck_out);
		psel_n = 1;
		clr();
	endtask : mx

	initial begin
		tick(12);
		reset = 0;
		tick(1);
		for (int i = 0; i < 6; i++)
			mx(rates[i % 3], i[0], i[1], i > 2);
		// Slave: bench is the far controller at a sixteenth of the clock.
		bm = 1;
		pin_dir = 4'h2;
		ctl(9'h180);
		g = $random(seed);
		m = $random(seed);
		data_in = g;
		data_write = 1;
		tick(1);
		data_write = 0;
		repeat (4) begin
			b_sck = 1;
			tick(8);
			b_sck = 0;
			tick(8);
		end
		chk("flag_idle", 0, transfer_done_flag);
		chk("miso_idle", 0, miso_oe);
		ss_in = 0;
		tick(8);
		for (int i = 7; i >= 0; i--) begin
			b_mosi = m[i];
			tick(8);
			chk("miso_oe", 1, miso_oe);
			data_in = {data_in[6:0], miso_out};
			b_sck = 1;
			tick(8);
			b_sck = 0;
		end
		wflag(40);
		chk("slave_out", g, data_in);
		chk("slave_rx", m, rx_data);
		chk("slave_irq", 1, irq);
		ss_in = 1;
		tick(8);
		chk("miso_off", 0, miso_oe);
		clr();
		// Another controller selects us while we are controller.
		bm = 0;
		pin_dir = 4'hC;
		ctl(9'h0B0);
		ss_in = 0;
		wflag(12);
		chk("demoted", 0, controller_select);
		chk("sck_released", 0, sck_oe);
		chk("mosi_released", 0, mosi_oe);
		conclude();
	end
endmodule : testbench
